// >>> include/lko_pkg.sv
// package for the local key operation block: constants, register map and state types
`default_nettype none
package lko_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TIMEOUT_MS = 2000;
  localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned COMBO_MS = 100;
  localparam int unsigned COMBO_CYC = (CLK_HZ / 1000) * COMBO_MS;
  localparam int unsigned DOUBLE_MS = 1000;
  localparam int unsigned DOUBLE_CYC = (CLK_HZ / 1000) * DOUBLE_MS;
  localparam int unsigned REP_SLOW_MS = 500;
  localparam int unsigned REP_SLOW_CYC = (CLK_HZ / 1000) * REP_SLOW_MS;
  localparam int unsigned REP_FAST_MS = 50;
  localparam int unsigned REP_FAST_CYC = (CLK_HZ / 1000) * REP_FAST_MS;
  localparam int unsigned REP_DIV = 2;
  localparam int unsigned VAL_W = 16;
  localparam int unsigned CNT_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PRESSURE = 8'h08;
  localparam logic [7:0] OFS_LOWER = 8'h0C;
  localparam logic [7:0] OFS_UPPER = 8'h10;
  localparam logic [7:0] OFS_BIAS = 8'h14;
  localparam logic [7:0] OFS_SHOWN = 8'h18;
  // ctrl fields
  localparam int unsigned CTRL_DISP_EN = 0;
  // status fields
  localparam int unsigned ST_CAL = 0;
  localparam int unsigned ST_LOCK = 1;
  localparam int unsigned ST_POINT_SPAN = 2;
  localparam int unsigned ST_SHOW_BIAS = 3;
  localparam int unsigned ST_KEYS = 4;
  // reset values and bus response codes
  localparam logic [15:0] LOWER_RST = 16'h0000;
  localparam logic [15:0] UPPER_RST = 16'h03E8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // key bit positions
  localparam int unsigned K_ZU = 0;
  localparam int unsigned K_ZD = 1;
  localparam int unsigned K_SU = 2;
  localparam int unsigned K_SD = 3;

  typedef enum logic [2:0] {
    LKO_IDLE,
    LKO_GATHER,
    LKO_HELD,
    LKO_RELEASE
  } lko_key_e;

  typedef struct packed {
    logic [3:0] k_meta;
    logic [3:0] k_sync;
    logic [3:0] k_stable;
    logic [CNT_W-1:0] deb_cnt;
    lko_key_e state;
    logic [3:0] combo;
    logic [CNT_W-1:0] gather_cnt;
    logic [CNT_W-1:0] rep_cnt;
    logic [CNT_W-1:0] rep_period;
    logic [CNT_W-1:0] idle_cnt;
    logic [CNT_W-1:0] dbl_cnt;
    logic [3:0] last_combo;
    logic cal_mode;
    logic point_span;
    logic show_bias;
    logic locked;
    logic [VAL_W-1:0] lower;
    logic [VAL_W-1:0] upper;
    logic [VAL_W-1:0] bias;
    logic [VAL_W-1:0] shown;
    logic [VAL_W-1:0] bar;
    logic disp_en;
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lko_state_s;
endpackage
`default_nettype wire

// >>> rtl/lko_keys.sv
// local four-key operator interface: key decode, range values, bias, lock, display
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module lko_keys
  import lko_pkg::*;
#(
  parameter int unsigned TIMEOUT = TIMEOUT_CYC,
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC,
  parameter int unsigned COMBO_WIN = COMBO_CYC,
  parameter int unsigned DOUBLE_WIN = DOUBLE_CYC,
  parameter int unsigned REP_SLOW = REP_SLOW_CYC,
  parameter int unsigned REP_FAST = REP_FAST_CYC
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // push keys, active low, from pins
  input wire logic [3:0] key_n_in,
  // measured pressure, same clock domain
  input wire logic [VAL_W-1:0] pressure_in,
  // display and transfer outputs
  output logic cal_mode_out,
  output logic point_span_out,
  output logic locked_out,
  output logic [VAL_W-1:0] display_value_out,
  output logic [VAL_W-1:0] bar_value_out,
  output logic [VAL_W-1:0] lower_out,
  output logic [VAL_W-1:0] upper_out,
  output logic [VAL_W-1:0] output_pressure_out,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr_in,
  input wire logic s_awvalid_in,
  output logic s_awready_out,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  input wire logic s_wvalid_in,
  output logic s_wready_out,
  output logic [1:0] s_bresp_out,
  output logic s_bvalid_out,
  input wire logic s_bready_in,
  input wire logic [7:0] s_araddr_in,
  input wire logic s_arvalid_in,
  output logic s_arready_out,
  output logic [31:0] s_rdata_out,
  output logic [1:0] s_rresp_out,
  output logic s_rvalid_out,
  input wire logic s_rready_in
);

  lko_state_s r;
  lko_state_s next_r;

  // **********************************************
  // key event decode and value arithmetic
  // **********************************************
  logic [3:0] pressed;
  logic [CNT_W-1:0] fast_next;
  logic step;
  logic do_write;
  logic [31:0] rd_word;

  assign pressed = r.k_stable;
  assign do_write = r.aw_hold && r.w_hold && !r.bvalid;

  always_comb begin
    next_r = r;
    step = 1'b0;
    rd_word = 32'h0000_0000;
    fast_next = r.rep_period / REP_DIV;

    // ********************************************
    // key synchroniser and debounce
    // ********************************************
    // contact bounce shorter than the debounce count never reaches the decoder
    next_r.k_meta = ~key_n_in;
    next_r.k_sync = r.k_meta;
    if (r.k_sync != r.k_stable) begin
      if (r.deb_cnt >= DEBOUNCE - 1) begin
        next_r.k_stable = r.k_sync;
        next_r.deb_cnt = '0;
      end else begin
        next_r.deb_cnt = r.deb_cnt + 1'b1;
      end
    end else begin
      next_r.deb_cnt = '0;
    end

    // ********************************************
    // activity timeout back to measurement mode
    // ********************************************
    if (r.cal_mode && pressed == 4'h0) begin
      if (r.idle_cnt >= TIMEOUT - 1) begin
        next_r.cal_mode = 1'b0;
        next_r.show_bias = 1'b0;
        next_r.idle_cnt = '0;
      end else begin
        next_r.idle_cnt = r.idle_cnt + 1'b1;
      end
    end else begin
      next_r.idle_cnt = '0;
    end

    if (r.dbl_cnt != '0) begin
      next_r.dbl_cnt = r.dbl_cnt - 1'b1;
    end else begin
      next_r.last_combo = 4'h0;
    end

    // ********************************************
    // press and combination decoder
    // ********************************************
    case (r.state)
      LKO_IDLE: begin
        if (pressed != 4'h0) begin
          next_r.state = LKO_GATHER;
          next_r.combo = pressed;
          next_r.gather_cnt = '0;
        end
      end
      // wait so that near-simultaneous presses form one combination
      LKO_GATHER: begin
        next_r.combo = r.combo | pressed;
        next_r.gather_cnt = r.gather_cnt + 1'b1;
        if (pressed == 4'h0 || r.gather_cnt >= COMBO_WIN - 1) begin
          next_r.state = LKO_HELD;
          next_r.rep_period = REP_SLOW;
          next_r.rep_cnt = '0;
          if ($countones(next_r.combo) == 1) begin
            if (!r.cal_mode) begin
              next_r.cal_mode = 1'b1;
            end else if (!r.locked) begin
              step = 1'b1;
            end
            next_r.point_span = next_r.combo[K_SU] | next_r.combo[K_SD];
            next_r.show_bias = 1'b0;
          end else if ($countones(next_r.combo) == 2) begin
            next_r.cal_mode = 1'b1;
            if (next_r.combo == 4'b0110) begin
              next_r.locked = 1'b0;
            end else if (next_r.combo == 4'b1001) begin
              next_r.locked = 1'b1;
            end else if (!r.locked) begin
              if (next_r.combo == 4'b0011) begin
                next_r.upper = r.upper + (pressure_in - r.lower);
                next_r.lower = pressure_in;
                next_r.point_span = 1'b0;
              end else if (next_r.combo == 4'b1100) begin
                next_r.upper = pressure_in;
                next_r.point_span = 1'b1;
              end else if (next_r.combo == 4'b0101) begin
                if (r.last_combo == 4'b0101) begin
                  next_r.bias = pressure_in;
                  next_r.last_combo = 4'h0;
                end else begin
                  next_r.show_bias = 1'b1;
                  next_r.last_combo = 4'b0101;
                  next_r.dbl_cnt = DOUBLE_WIN;
                end
              end else if (next_r.combo == 4'b1010) begin
                if (r.last_combo == 4'b1010) begin
                  next_r.bias = '0;
                  next_r.last_combo = 4'h0;
                end else begin
                  next_r.last_combo = 4'b1010;
                  next_r.dbl_cnt = DOUBLE_WIN;
                end
              end
            end
          end
        end
      end
      LKO_HELD: begin
        if (pressed == 4'h0) begin
          next_r.state = LKO_IDLE;
        end else if ($countones(r.combo) == 1 && r.cal_mode && !r.locked) begin
          // repeat: slow first, then each interval shorter down to the floor
          if (r.rep_cnt >= r.rep_period - 1) begin
            step = 1'b1;
            next_r.rep_cnt = '0;
            next_r.rep_period = (fast_next < REP_FAST) ? REP_FAST : fast_next;
          end else begin
            next_r.rep_cnt = r.rep_cnt + 1'b1;
          end
        end
      end
      default: begin
        next_r.state = LKO_IDLE;
      end
    endcase

    // ********************************************
    // single-key stepping
    // ********************************************
    if (step) begin
      if (r.combo[K_ZU] || next_r.combo[K_ZU] && r.state == LKO_GATHER) begin
        next_r.lower = r.lower + 1'b1;
        next_r.upper = r.upper + 1'b1;
      end else if (next_r.combo[K_ZD]) begin
        next_r.lower = r.lower - 1'b1;
        next_r.upper = r.upper - 1'b1;
      end else if (next_r.combo[K_SU]) begin
        next_r.upper = r.upper + 1'b1;
      end else if (next_r.combo[K_SD]) begin
        next_r.upper = r.upper - 1'b1;
      end
    end

    // ********************************************
    // display figures
    // ********************************************
    // bias applies to the display and the bar graph alone
    if (r.show_bias) begin
      next_r.shown = r.bias;
    end else if (r.cal_mode) begin
      next_r.shown = r.point_span ? r.upper : r.lower;
    end else begin
      next_r.shown = pressure_in - r.bias;
    end
    // bar graph follows the measurement even while a setting is shown
    next_r.bar = pressure_in - r.bias;

    // ********************************************
    // axi4-lite slave
    // ********************************************
    if (s_awvalid_in && !r.aw_hold) begin
      next_r.aw_hold = 1'b1;
      next_r.aw_addr = s_awaddr_in;
    end
    if (s_wvalid_in && !r.w_hold) begin
      next_r.w_hold = 1'b1;
      next_r.w_data = s_wdata_in;
      next_r.w_strb = s_wstrb_in;
    end
    if (do_write) begin
      next_r.aw_hold = 1'b0;
      next_r.w_hold = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (r.aw_addr == OFS_CTRL) begin
        if (r.w_strb[0]) begin
          next_r.disp_en = r.w_data[CTRL_DISP_EN];
        end
      end else if (r.aw_addr == OFS_STATUS || r.aw_addr == OFS_PRESSURE) begin
        next_r.bresp = RESP_OKAY;
      end else if (r.aw_addr == OFS_LOWER || r.aw_addr == OFS_UPPER) begin
        next_r.bresp = RESP_OKAY;
      end else if (r.aw_addr == OFS_BIAS || r.aw_addr == OFS_SHOWN) begin
        next_r.bresp = RESP_OKAY;
      end else begin
        next_r.bresp = RESP_SLVERR;
      end
    end
    if (r.bvalid && s_bready_in) begin
      next_r.bvalid = 1'b0;
    end

    // ********************************************
    // read decode
    // ********************************************
    if (s_araddr_in == OFS_CTRL) begin
      rd_word[CTRL_DISP_EN] = r.disp_en;
    end else if (s_araddr_in == OFS_STATUS) begin
      rd_word[ST_CAL] = r.cal_mode;
      rd_word[ST_LOCK] = r.locked;
      rd_word[ST_POINT_SPAN] = r.point_span;
      rd_word[ST_SHOW_BIAS] = r.show_bias;
      rd_word[ST_KEYS +: 4] = r.k_stable;
    end else if (s_araddr_in == OFS_PRESSURE) begin
      rd_word[VAL_W-1:0] = pressure_in;
    end else if (s_araddr_in == OFS_LOWER) begin
      rd_word[VAL_W-1:0] = r.lower;
    end else if (s_araddr_in == OFS_UPPER) begin
      rd_word[VAL_W-1:0] = r.upper;
    end else if (s_araddr_in == OFS_BIAS) begin
      rd_word[VAL_W-1:0] = r.bias;
    end else if (s_araddr_in == OFS_SHOWN) begin
      rd_word[VAL_W-1:0] = r.shown;
    end
    if (s_arvalid_in && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_word;
      next_r.rresp = (s_araddr_in > OFS_SHOWN || s_araddr_in[1:0] != 2'h0)
        ? RESP_SLVERR : RESP_OKAY;
    end else if (r.rvalid && s_rready_in) begin
      next_r.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.state <= LKO_IDLE;
      r.lower <= LOWER_RST;
      r.upper <= UPPER_RST;
      r.disp_en <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // **********************************************
  // outputs
  // **********************************************
  assign cal_mode_out = r.cal_mode & r.disp_en;
  assign point_span_out = r.point_span;
  assign locked_out = r.locked;
  assign display_value_out = r.shown;
  assign bar_value_out = r.bar;
  assign lower_out = r.lower;
  assign upper_out = r.upper;
  // loop current is computed without the bias
  assign output_pressure_out = pressure_in;
  assign s_awready_out = !r.aw_hold;
  assign s_wready_out = !r.w_hold;
  assign s_bvalid_out = r.bvalid;
  assign s_bresp_out = r.bresp;
  assign s_arready_out = !r.rvalid;
  assign s_rvalid_out = r.rvalid;
  assign s_rdata_out = r.rdata;
  assign s_rresp_out = r.rresp;

endmodule
`default_nettype wire

// >>> verification/lko_asserts.sv
// checker for the local key operation block
`default_nettype none
module lko_asserts
  import lko_pkg::*;
#(
  parameter int unsigned TIMEOUT = 200,
  parameter int unsigned DEBOUNCE = 2
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // keys and pressure
  input wire logic [3:0] key_n_in,
  input wire logic [VAL_W-1:0] pressure_in,
  // observed outputs
  input wire logic cal_mode_out,
  input wire logic locked_out,
  input wire logic [VAL_W-1:0] lower_out,
  input wire logic [VAL_W-1:0] upper_out,
  input wire logic [VAL_W-1:0] output_pressure_out,
  // bus handshakes
  input wire logic s_arvalid_in,
  input wire logic s_arready_out,
  input wire logic s_rvalid_out,
  input wire logic s_bvalid_out,
  input wire logic s_bready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // cycles with every key up; saturates so it never wraps back to zero
  logic [CNT_W-1:0] idle;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) idle <= '0;
    else if (key_n_in != 4'hF) idle <= '0;
    else if (idle != '1) idle <= idle + 1;
  end
  chk_out_unbiased: assert property (output_pressure_out == pressure_in)
    else $error("current output pressure differs from measured pressure");
  chk_cal_timeout: assert property (idle > TIMEOUT + DEBOUNCE + 16 |-> !cal_mode_out)
    else $error("calibration display outlived its timeout");
  chk_quiet_hold: assert property (idle > 16 |-> $stable(lower_out) && $stable(upper_out))
    else $error("range value moved with no key held");
  chk_lock_freeze: assert property (locked_out |=> $stable(lower_out) && $stable(upper_out))
    else $error("range value moved while locked");
  chk_span_kept: assert property ($changed(lower_out) |->
    upper_out - lower_out == $past(upper_out) - $past(lower_out))
    else $error("span changed with lower value");
  chk_wake_only: assert property ($rose(cal_mode_out) |-> $stable(lower_out))
    else $error("wake press altered lower value");
  chk_change_cal: assert property ($changed(lower_out) |-> ##[0:1] cal_mode_out)
    else $error("lower value changed outside calibration display");
  chk_reset_range: assert property ($fell(rst_in) |->
    lower_out == LOWER_RST && upper_out == UPPER_RST && !cal_mode_out)
    else $error("range values wrong after reset");
  chk_read_next: assert property (s_arvalid_in && s_arready_out |=> s_rvalid_out)
    else $error("read answer late");
  chk_write_done: assert property (s_bvalid_out && s_bready_in |=> !s_bvalid_out)
    else $error("write response repeated");
  cover property ($rose(locked_out));
  cover property ($changed(lower_out));
  cover property (idle > TIMEOUT + DEBOUNCE + 16);
endmodule
bind lko_keys lko_asserts #(.TIMEOUT(TIMEOUT), .DEBOUNCE(DEBOUNCE)) lko_asserts_i (
  .ref_clk_in, .rst_in, .key_n_in, .pressure_in, .cal_mode_out, .locked_out, .lower_out,
  .upper_out, .output_pressure_out, .s_arvalid_in, .s_arready_out, .s_rvalid_out,
  .s_bvalid_out, .s_bready_in);
`default_nettype wire

// >>> verification/lko_keypad.sv
// model of the operator pressing the four keys
`default_nettype none
module lko_keypad (
  // clock
  input wire logic clk_in,
  // keys to the pins, low while pressed, pulled up when released
  output logic [3:0] key_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial key_n_out = 4'hF;
  // press keys together, hold, release, rest; returns once outputs settle
  task automatic press(input logic [3:0] keys, input int hold, input int rest);
    key_n_out <= ~keys;
    repeat (hold) @(posedge clk_in);
    key_n_out <= 4'hF;
    repeat (rest) @(posedge clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the local key operation block
`default_nettype none
module tb_top
  import lko_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ZU = 4'h1, ZD = 4'h2, SU = 4'h4, SD = 4'h8;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, cal, span_pt, locked;
  logic [3:0] key_n;
  logic [VAL_W-1:0] pressure = 16'h0000, disp, bar, lower, upper, outp, exp_lo, exp_up;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  int error_cnt = 0, n_compared = 0;
  initial forever #4 ref_clk_in = ~ref_clk_in;
  lko_keypad keypad_i (.clk_in(ref_clk_in), .key_n_out(key_n));
  lko_keys #(.TIMEOUT(200), .DEBOUNCE(2), .COMBO_WIN(4), .REP_SLOW(20),
    .REP_FAST(4)) lko_keys_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .key_n_in(key_n),
    .pressure_in(pressure), .cal_mode_out(cal), .point_span_out(span_pt),
    .locked_out(locked), .display_value_out(disp), .bar_value_out(bar), .lower_out(lower),
    .upper_out(upper), .output_pressure_out(outp), .s_awaddr_in(awaddr),
    .s_awvalid_in(awvalid), .s_awready_out(awready), .s_wdata_in(wdata),
    .s_wstrb_in(wstrb), .s_wvalid_in(wvalid), .s_wready_out(wready), .s_bresp_out(bresp),
    .s_bvalid_out(bvalid), .s_bready_in(bready), .s_araddr_in(araddr),
    .s_arvalid_in(arvalid), .s_arready_out(arready), .s_rdata_out(rdata),
    .s_rresp_out(rresp), .s_rvalid_out(rvalid), .s_rready_in(rready));
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  // handshakes are sampled at the falling edge, acted on after the rising one
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
    input logic [1:0] er);
    logic ta, tw, done;
    done = 1'b0;
    @(posedge ref_clk_in);
    awaddr <= a;
    wstrb <= s;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge ref_clk_in);
      ta = awready;
      tw = wready;
      done = bvalid;
      r = bresp;
      @(posedge ref_clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    check("bresp", {30'h0, er}, {30'h0, r});
    if (!done) error_cnt++;
    if (!done) tally_and_finish();
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ta, done;
    done = 1'b0;
    @(posedge ref_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge ref_clk_in);
      ta = arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge ref_clk_in);
      if (ta) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done) error_cnt++;
    if (!done) tally_and_finish();
  endtask
  task automatic step(input logic [3:0] k, input logic [15:0] dl, input logic [15:0] du);
    keypad_i.press(k, 10, 10);
    exp_lo += dl;
    exp_up += du;
    check("lower", exp_lo, lower);
    check("upper", exp_up, upper);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    check("cal", 32'h0, cal);
    axi_rd(OFS_CTRL);
    check("ctrl", 32'h1, d);
    axi_rd(8'h40);
    check("rresp", RESP_SLVERR, r);
    axi_wr(OFS_CTRL, 32'h0, 4'h0, RESP_OKAY);
    axi_rd(OFS_CTRL);
    check("ctrl", 32'h1, d);
    axi_wr(OFS_CTRL, 32'h0, 4'hF, RESP_OKAY);
    axi_rd(OFS_CTRL);
    check("ctrl", 32'h0, d);
    axi_wr(OFS_CTRL, 32'h1, 4'hF, RESP_OKAY);
    axi_wr(8'h40, 32'h0, 4'hF, RESP_SLVERR);
    // wake press: display changes, values do not
    exp_lo = LOWER_RST;
    exp_up = UPPER_RST;
    step(ZU, 16'h0000, 16'h0000);
    check("cal", 32'h1, cal);
    step(ZU, 16'h0001, 16'h0001);
    step(ZD, 16'hFFFF, 16'hFFFF);
    step(SU, 16'h0000, 16'h0001);
    step(SD, 16'h0000, 16'hFFFF);
    check("point", 32'h1, span_pt);
    // held key speeds up: more steps than the slow rate alone gives
    keypad_i.press(ZU, 120, 10);
    check("fast", 32'h1, 32'(lower - exp_lo > 16'h0008));
    check("span", exp_up - exp_lo, upper - lower);
    exp_up = upper - lower;
    pressure <= 16'h0200;
    keypad_i.press(ZU | ZD, 10, 10);
    check("lower", 32'h0200, lower);
    check("upper", 32'h0200 + exp_up, upper);
    check("point", 32'h0, span_pt);
    exp_lo = 16'h0200;
    pressure <= 16'h0900;
    keypad_i.press(SU | SD, 10, 10);
    check("upper", 32'h0900, upper);
    check("lower", exp_lo, lower);
    pressure <= 16'h0040;
    keypad_i.press(ZU | SU, 10, 10);
    keypad_i.press(ZU | SU, 10, 60);
    axi_rd(OFS_BIAS);
    check("bias", 32'h0040, d);
    pressure <= 16'h0150;
    keypad_i.press(ZU | SU, 10, 60);
    axi_rd(OFS_BIAS);
    check("bias", 32'h0040, d);
    check("display", 32'h0040, disp);
    check("bar", 32'h0110, bar);
    repeat (260) @(posedge ref_clk_in);
    #1;
    check("cal", 32'h0, cal);
    check("display", 32'h0110, disp);
    check("output", 32'h0150, outp);
    keypad_i.press(ZU | SD, 10, 10);
    check("locked", 32'h1, locked);
    keypad_i.press(ZU, 10, 10);
    keypad_i.press(ZU | ZD, 10, 10);
    check("lower", exp_lo, lower);
    check("upper", 32'h0900, upper);
    keypad_i.press(ZD | SU, 10, 10);
    check("locked", 32'h0, locked);
    keypad_i.press(ZD | SD, 10, 10);
    keypad_i.press(ZD | SD, 10, 10);
    axi_rd(OFS_BIAS);
    check("bias", 32'h0, d);
    tally_and_finish();
  end
endmodule
`default_nettype wire
